// file: design/css_pkg.sv
package css_pkg;
    // system clock and separator tick rate
    localparam int unsigned SYS_CLK_HZ = 20000000;
    localparam int unsigned SEP_CLK_HZ = 5000000;
    localparam int unsigned SEP_DIV = SYS_CLK_HZ / SEP_CLK_HZ;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] THRESH_RESET = 8'h20;
    // control bit positions
    localparam int SYNC_CTRL_HSRC_BIT = 3;
    localparam int SYNC_CTRL_OVR_BIT = 1;
    localparam int SYNC_CTRL_VSRC_BIT = 0;
    localparam int IF_CTRL_DIG_BIT = 1;
    typedef enum logic [0:0] {
        CSS_SEARCH,
        CSS_VS_ON
    } css_state_e;
endpackage

// file: design/css_tick_if.sv
`timescale 1ns/1ps
interface css_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// file: design/css_tick_div.sv
`timescale 1ns/1ps
module css_tick_div #(
    parameter int DIV = css_pkg::SEP_DIV
) (
    input wire logic clk,
    input wire logic rst,
    css_tick_if.src tk
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    wire wrap = (cnt_q == 8'(DIV - 1));
    assign cnt_d = wrap ? 8'h00 : cnt_q + 8'h01;
    assign tk.tick = wrap;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// file: design/css_top.sv
`timescale 1ns/1ps
// What this block does
// R1 - hsync mux passes the dedicated hsync when control bit 3 of 0x10 is 0, green-channel sync when 1.
// R2 - vsync mux passes the dedicated vsync when control bit 0 of 0x10 is 0, separator vsync when 1.
// R3 - output muxes pass analog-path signals when bit 1 of 0x0F is 0, digital-path signals when 1.
// R4 - the separator is an eight-bit counter advancing on a 5 MHz tick.
// R5 - the separator works the same whatever the polarity, as its input arrives active high.
// R6 - while searching and composite sync is active the counter increments once per tick.
// R7 - when the pulse ends the counter decrements once per tick and stops at zero.
// R8 - vertical sync is declared once the count exceeds the programmable threshold.
// R9 - on detection the counter clears, then counts up only while composite sync is inactive.
// R10 - vertical sync is declared absent only when that post-detection count reaches the threshold.
// R11 - after absence the counter clears and the search state resumes.
// R12 - with override set, the active vertical source flag equals the vsync select bit.
// R13 - the counter saturates at all ones rather than wrapping.
// R14 - the extracted vsync stays high from detection to absence and low otherwise.
module css_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] SYNC_CTRL,
    input wire logic [7:0] IF_CTRL,
    input wire logic [7:0] SEP_THRESH,
    input wire logic HSYNC_IN,
    input wire logic GREEN_CHANNEL_SYNC,
    input wire logic VSYNC_IN,
    input wire logic CSYNC_ACT,
    input wire logic DIG_HSYNC,
    input wire logic DIG_VSYNC,
    input wire logic DIG_DE,
    input wire logic ANA_DE,
    output logic HSYNC_OUT,
    output logic VSYNC_OUT,
    output logic DE_OUT,
    output logic SEP_VSYNC,
    output logic VSYNC_DETECT,
    output logic ACTIVE_VERTICAL_SOURCE_FLAG,
    output logic [7:0] SEP_COUNT
);
    css_tick_if tk ();
    css_tick_div #(.DIV(css_pkg::SEP_DIV)) u_div (
        .clk(SYS_CLK),
        .rst(RST),
        .tk(tk)
    );

    // input is already active high; polarity is resolved upstream
    wire act = CSYNC_ACT; // R5
    wire hsrc_sel = SYNC_CTRL[css_pkg::SYNC_CTRL_HSRC_BIT];
    wire vsrc_sel = SYNC_CTRL[css_pkg::SYNC_CTRL_VSRC_BIT];
    wire ovr = SYNC_CTRL[css_pkg::SYNC_CTRL_OVR_BIT];
    wire dig_sel = IF_CTRL[css_pkg::IF_CTRL_DIG_BIT];

    css_pkg::css_state_e st_q;
    css_pkg::css_state_e st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic vs_q;

    wire at_max = (cnt_q == css_pkg::CNT_MAX);
    wire at_zero = (cnt_q == css_pkg::CNT_RESET);
    wire over_th = (cnt_q > SEP_THRESH); // R8
    wire reach_th = (cnt_q >= SEP_THRESH); // R10
    wire [7:0] cnt_inc = at_max ? cnt_q : cnt_q + 8'h01; // R13
    wire [7:0] cnt_dec = at_zero ? cnt_q : cnt_q - 8'h01; // R7

    // decisions and counting both happen on the 5 MHz tick only
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (tk.tick) begin // R4
            case (st_q)
                css_pkg::CSS_SEARCH: begin
                    if (over_th) begin
                        st_d = css_pkg::CSS_VS_ON;
                        cnt_d = css_pkg::CNT_RESET; // R9
                    end else if (act) begin
                        cnt_d = cnt_inc; // R6
                    end else begin
                        cnt_d = cnt_dec; // R7
                    end
                end
                css_pkg::CSS_VS_ON: begin
                    // serration pulses hold the count rather than ending vsync
                    if (reach_th) begin
                        st_d = css_pkg::CSS_SEARCH; // R11
                        cnt_d = css_pkg::CNT_RESET; // R11
                    end else if (!act) begin
                        cnt_d = cnt_inc; // R9
                    end
                end
                default: begin
                    st_d = css_pkg::CSS_SEARCH;
                    cnt_d = css_pkg::CNT_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_q <= css_pkg::CSS_SEARCH;
            cnt_q <= css_pkg::CNT_RESET;
            vs_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            vs_q <= (st_d == css_pkg::CSS_VS_ON); // R14
        end
    end

    wire ana_hs = hsrc_sel ? GREEN_CHANNEL_SYNC : HSYNC_IN; // R1
    wire ana_vs = vsrc_sel ? vs_q : VSYNC_IN; // R2
    wire hs_d = dig_sel ? DIG_HSYNC : ana_hs; // R3
    wire vsel_d = dig_sel ? DIG_VSYNC : ana_vs; // R3
    wire de_d = dig_sel ? DIG_DE : ANA_DE; // R3
    // with override the flag follows the select bit, else it reports detection
    wire act_src_d = ovr ? vsrc_sel : vs_q; // R12

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            HSYNC_OUT <= 1'b0;
            VSYNC_OUT <= 1'b0;
            DE_OUT <= 1'b0;
            ACTIVE_VERTICAL_SOURCE_FLAG <= 1'b0;
        end else begin
            HSYNC_OUT <= hs_d;
            VSYNC_OUT <= vsel_d;
            DE_OUT <= de_d;
            ACTIVE_VERTICAL_SOURCE_FLAG <= act_src_d;
        end
    end

    assign SEP_VSYNC = vs_q;
    assign VSYNC_DETECT = vs_q;
    assign SEP_COUNT = cnt_q;
endmodule

// file: verification/css_top_monitor.sv
`timescale 1ns/1ps
module css_top_monitor (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSYNC_IN,
    input wire logic GREEN_CHANNEL_SYNC,
    input wire logic VSYNC_IN,
    input wire logic CSYNC_ACT,
    input wire logic DIG_HSYNC,
    input wire logic DIG_VSYNC,
    input wire logic DIG_DE,
    input wire logic ANA_DE,
    input wire logic HSYNC_OUT,
    input wire logic VSYNC_OUT,
    input wire logic DE_OUT,
    input wire logic SEP_VSYNC,
    input wire logic VSYNC_DETECT,
    input wire logic ACTIVE_VERTICAL_SOURCE_FLAG,
    input wire logic [7:0] SYNC_CTRL,
    input wire logic [7:0] IF_CTRL,
    input wire logic [7:0] SEP_THRESH,
    input wire logic [7:0] SEP_COUNT
);
    wire logic h_exp = IF_CTRL[1] ? DIG_HSYNC : SYNC_CTRL[3] ? GREEN_CHANNEL_SYNC : HSYNC_IN;
    wire logic v_exp = IF_CTRL[1] ? DIG_VSYNC : SYNC_CTRL[0] ? SEP_VSYNC : VSYNC_IN;
    wire logic d_exp = IF_CTRL[1] ? DIG_DE : ANA_DE;
    wire logic a_exp = SYNC_CTRL[1] ? SYNC_CTRL[0] : VSYNC_DETECT;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_hsync_mux: assert property (!$past(RST) |-> HSYNC_OUT == $past(h_exp)) else $error("hsync out");
    a_vsync_mux: assert property (!$past(RST) |-> VSYNC_OUT == $past(v_exp)) else $error("vsync out");
    a_de_mux: assert property (!$past(RST) |-> DE_OUT == $past(d_exp)) else $error("de out");
    a_active_src_flag: assert property (!$past(RST) |-> ACTIVE_VERTICAL_SOURCE_FLAG == $past(a_exp))
        else $error("active source flag");
    a_count_step: assert property ($changed(SEP_COUNT) |-> SEP_COUNT == 8'h00 ||
        SEP_COUNT == $past(SEP_COUNT) + 8'h01 || SEP_COUNT == $past(SEP_COUNT) - 8'h01) else $error("count step");
    a_tick_rate: assert property ($changed(SEP_COUNT) |=> $stable(SEP_COUNT) [*3]) else $error("count rate");
    a_detect_on: assert property ($rose(VSYNC_DETECT) |-> SEP_COUNT == 8'h00 &&
        $past(SEP_COUNT) > $past(SEP_THRESH)) else $error("detect");
    a_detect_off: assert property (!$past(RST) && $fell(VSYNC_DETECT) |-> SEP_COUNT == 8'h00 &&
        $past(SEP_COUNT) >= $past(SEP_THRESH)) else $error("absence");
    a_sep_level: assert property (SEP_VSYNC == VSYNC_DETECT) else $error("sep level");
    // while searching, a count step is up exactly when composite sync was active at that tick
    a_search_dir: assert property (!VSYNC_DETECT && !$past(VSYNC_DETECT) && $changed(SEP_COUNT) |->
        (SEP_COUNT == $past(SEP_COUNT) + 8'h01) == $past(CSYNC_ACT)) else $error("search count direction");
    a_vson_count: assert property (VSYNC_DETECT && $past(VSYNC_DETECT) && $changed(SEP_COUNT) |->
        SEP_COUNT == $past(SEP_COUNT) + 8'h01 && !$past(CSYNC_ACT)) else $error("vsync on count");
    a_vs_edge_clear: assert property ($changed(VSYNC_DETECT) |-> SEP_COUNT == 8'h00)
        else $error("vsync edge without clear");
endmodule
bind css_top css_top_monitor u_mon (.*);

// file: verification/css_sync_src.sv
`timescale 1ns/1ps
module css_sync_src (
    input wire logic clk,
    input wire logic vs_en,
    output logic csync
);
    // short line pulse of two ticks every 64 cycles, long pulse while vs_en
    logic [5:0] ph_q = 6'h00;
    always_ff @(posedge clk) ph_q <= ph_q + 6'h01;
    assign csync = vs_en | (ph_q < 6'h08);
endmodule

// file: verification/css_top_tb.sv
`timescale 1ns/1ps
module css_top_tb;
    logic SYS_CLK = 0, RST = 1, HSYNC_IN = 0, VSYNC_IN = 0, DIG_HSYNC = 0, DIG_VSYNC = 0, DIG_DE = 0, ANA_DE = 0;
    logic vs_en = 0, GREEN_CHANNEL_SYNC = 0;
    logic [7:0] SYNC_CTRL = 8'h00, IF_CTRL = 8'h00, SEP_THRESH = 8'h10;
    wire logic CSYNC_ACT, HSYNC_OUT, VSYNC_OUT, DE_OUT, SEP_VSYNC, VSYNC_DETECT;
    wire logic ACTIVE_VERTICAL_SOURCE_FLAG;
    wire logic [7:0] SEP_COUNT;
    int fails = 0, n_compared = 0;
    // hsrc, green, vsrc, dig, hs, vs, dig hs, dig vs, dig de, ana de, then expected hs, vs, de
    logic [12:0] rows [7] = '{13'b0000100101101, 13'b0100011010010, 13'b1001001110111, 13'b1101110001000,
        13'b1100000001101, 13'b1000111110010, 13'b0110010000000};
    css_top uut (.*);
    css_sync_src u_src (.clk(SYS_CLK), .vs_en(vs_en), .csync(CSYNC_ACT));
    always #25 SYS_CLK = ~SYS_CLK;
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h got %h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task wt(input logic v);
        for (int i = 0; i < 2000 && VSYNC_DETECT !== v; i++) cyc(1);
        chk(VSYNC_DETECT, v, "detect");
    endtask
    initial begin
        cyc(16);
        RST = 0;
        foreach (rows[i]) begin
            {SYNC_CTRL[3], GREEN_CHANNEL_SYNC, SYNC_CTRL[0], IF_CTRL[1], HSYNC_IN, VSYNC_IN,
                DIG_HSYNC, DIG_VSYNC, DIG_DE, ANA_DE} = rows[i][12:3];
            cyc(2);
            chk({HSYNC_OUT, VSYNC_OUT, DE_OUT}, rows[i][2:0], "mux");
        end
        vs_en = 1;
        wt(1);
        cyc(40);
        chk(SEP_COUNT, 8'h00, "count held");
        chk(VSYNC_OUT, 1, "vsync out");
        chk(SEP_VSYNC, 1, "sep vsync");
        chk(ACTIVE_VERTICAL_SOURCE_FLAG, 1, "source flag");
        SYNC_CTRL = 8'h02;
        cyc(2);
        chk(ACTIVE_VERTICAL_SOURCE_FLAG, 0, "source flag forced low");
        vs_en = 0;
        wt(0);
        chk(SEP_COUNT, 8'h00, "count cleared");
        SYNC_CTRL = 8'h03;
        cyc(2);
        chk(ACTIVE_VERTICAL_SOURCE_FLAG, 1, "source flag forced high");
        chk(VSYNC_OUT, 0, "separator selected");
        SEP_THRESH = 8'hff;
        HSYNC_IN = 1;
        ANA_DE = 1;
        RST = 1;
        cyc(2);
        chk({3'h0, HSYNC_OUT, VSYNC_OUT, DE_OUT, ACTIVE_VERTICAL_SOURCE_FLAG, VSYNC_DETECT}, 8'h00, "reset outs");
        chk(SEP_COUNT, 8'h00, "reset count");
        RST = 0;
        vs_en = 1;
        cyc(1100);
        chk(SEP_COUNT, 8'hff, "saturate");
        vs_en = 0;
        cyc(1400);
        chk(SEP_COUNT < 8'h03, 1, "decay");
        stop_test;
    end
    initial begin
        repeat (6000) @(posedge SYS_CLK);
        fails++;
        stop_test;
    end
endmodule
